/* verilog/indexed_operand_substitution.sv */
// Indexed-execute prefix handling: fetches the index word and rewrites the next instruction.
// Assumes the index word storage answers a request with idx_valid_in on a later cycle.
`timescale 1ns/1ps
module indexed_operand_substitution (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic instr_valid_in,
	input wire idx_sub_pkg::instr_s instr_in,
	output logic instr_ready_out,
	input wire logic logic_result_bit_in,
	output logic idx_req_out,
	output idx_sub_pkg::index_req_s idx_sel_out,
	input wire logic idx_valid_in,
	input wire logic [idx_sub_pkg::WORD_W-1:0] idx_data_in,
	output logic exec_valid_out,
	output idx_sub_pkg::exec_s exec_out,
	output logic illegal_pair_out
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_FETCH = 3'b010,
		ST_ARMED = 3'b100
	} state_e;

	state_e state_reg, state_next;
	idx_sub_pkg::index_req_s sel_reg;
	logic [idx_sub_pkg::WORD_W-1:0] index_reg;
	logic req_reg;
	logic exec_valid_reg;
	idx_sub_pkg::exec_s exec_reg;
	logic illegal_reg;

	wire take = instr_valid_in && instr_ready_out;
	wire is_prefix = instr_in.op == idx_sub_pkg::OP_DO;
	wire permitted;
	wire is_bit = (instr_in.opnd == idx_sub_pkg::OPND_INPUT) || (instr_in.opnd == idx_sub_pkg::OPND_OUTPUT)
		|| (instr_in.opnd == idx_sub_pkg::OPND_FLAG);
	wire [7:0] idx_byte = index_reg[idx_sub_pkg::BYTE_HI:idx_sub_pkg::BYTE_LO];
	wire [7:0] idx_bit = index_reg[idx_sub_pkg::BIT_HI:idx_sub_pkg::BIT_LO];
	wire remap_to_output = (instr_in.op == idx_sub_pkg::OP_AND) && (instr_in.opnd == idx_sub_pkg::OPND_INPUT)
		&& (sel_reg.space == idx_sub_pkg::SPACE_FLAG_WORD) && (idx_byte > idx_sub_pkg::INPUT_BYTE_LIMIT);
	wire armed = state_reg == ST_ARMED;
	wire emit = take && !is_prefix && (!armed || permitted);
	wire refuse = take && armed && !permitted;

	// The result bit is deliberately not consulted anywhere; it is left unused.
	wire unused_result_bit = logic_result_bit_in;

	op_class_check u_check (
		.op_in(instr_in.op),
		.permitted_out(permitted)
	);

	assign instr_ready_out = state_reg != ST_FETCH;
	assign idx_req_out = req_reg;
	assign idx_sel_out = sel_reg;
	assign exec_valid_out = exec_valid_reg;
	assign exec_out = exec_reg;
	assign illegal_pair_out = illegal_reg;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (take && is_prefix) begin
					state_next = ST_FETCH;
				end
			end
			ST_FETCH: begin
				if (idx_valid_in) begin
					state_next = ST_ARMED;
				end
			end
			ST_ARMED: begin
				if (take) begin
					state_next = ST_IDLE;
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_reg <= ST_IDLE;
			req_reg <= 1'b0;
			sel_reg <= '0;
			index_reg <= idx_sub_pkg::INDEX_RESET;
		end else begin
			state_reg <= state_next;
			req_reg <= take && is_prefix && !armed;
			if (take && is_prefix && !armed) begin
				sel_reg <= '{space: instr_in.space, word_num: instr_in.param[idx_sub_pkg::NUM_W-1:0]};
			end
			if (state_reg == ST_FETCH && idx_valid_in) begin
				index_reg <= idx_data_in;
			end
		end
	end

	// Refused pairings are dropped rather than executed, since running them could corrupt state.
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			exec_valid_reg <= 1'b0;
			exec_reg <= '0;
			illegal_reg <= 1'b0;
		end else begin
			exec_valid_reg <= emit;
			illegal_reg <= refuse;
			if (emit && armed) begin
				exec_reg.op <= instr_in.op;
				exec_reg.opnd <= remap_to_output ? idx_sub_pkg::OPND_OUTPUT : instr_in.opnd;
				exec_reg.indexed <= 1'b1;
				exec_reg.param <= index_reg;
				exec_reg.byte_addr <= idx_byte;
				exec_reg.bit_num <= is_bit ? idx_bit : 8'h00;
			end else if (emit) begin
				exec_reg.op <= instr_in.op;
				exec_reg.opnd <= instr_in.opnd;
				exec_reg.indexed <= 1'b0;
				exec_reg.param <= instr_in.param;
				exec_reg.byte_addr <= instr_in.param[idx_sub_pkg::BYTE_HI:idx_sub_pkg::BYTE_LO];
				exec_reg.bit_num <= instr_in.param[idx_sub_pkg::BIT_HI:idx_sub_pkg::BIT_LO];
			end
		end
	end
endmodule

/* verilog/idx_sub_pkg.sv */
// Shared types and constants for the indexed operand substitution logic.
// Assumes one clock domain and an instruction stream presented one word at a time.
// Functional notes
// - The prefix is a two-word statement run whatever the logic_result_bit holds.
// - The prefix word names a flag word or data word numbered 0 to 255.
// - The second word's parameter is replaced by the named word's current value.
// - Indexed bit operations take bit number from high byte, byte address from low.
// - Accepted classes: logic, set/reset, timer, counter, load/transfer, jump, shift, dec/inc, calls.
// - Input AND indexed via flag word with byte address above 127 becomes output AND.
package idx_sub_pkg;

	localparam int WORD_W = 16;
	localparam int NUM_W = 8;
	localparam logic [NUM_W-1:0] WORD_NUM_MAX = 8'hFF;
	localparam logic [7:0] INPUT_BYTE_LIMIT = 8'h7F;
	localparam int BIT_HI = 15;
	localparam int BIT_LO = 8;
	localparam int BYTE_HI = 7;
	localparam int BYTE_LO = 0;
	localparam logic [WORD_W-1:0] INDEX_RESET = 16'h0000;

	typedef enum logic [3:0] {
		OP_AND = 4'h0,
		OP_LOGIC_OTHER = 4'h1,
		OP_SET_RESET = 4'h2,
		OP_TIMER = 4'h3,
		OP_COUNTER = 4'h4,
		OP_LOAD_XFER = 4'h5,
		OP_JUMP = 4'h6,
		OP_SHIFT = 4'h7,
		OP_DEC_INC = 4'h8,
		OP_BLOCK_CALL = 4'h9,
		OP_DO = 4'hA,
		OP_OTHER = 4'hF
	} op_e;

	typedef enum logic [2:0] {
		OPND_NONE = 3'h0,
		OPND_INPUT = 3'h1,
		OPND_OUTPUT = 3'h2,
		OPND_FLAG = 3'h3,
		OPND_OTHER = 3'h4
	} opnd_e;

	typedef enum logic {
		SPACE_FLAG_WORD = 1'b0,
		SPACE_DATA_WORD = 1'b1
	} space_e;

	typedef struct packed {
		op_e op;
		opnd_e opnd;
		space_e space;
		logic [WORD_W-1:0] param;
	} instr_s;

	typedef struct packed {
		op_e op;
		opnd_e opnd;
		logic indexed;
		logic [7:0] byte_addr;
		logic [7:0] bit_num;
		logic [WORD_W-1:0] param;
	} exec_s;

	typedef struct packed {
		space_e space;
		logic [NUM_W-1:0] word_num;
	} index_req_s;

endpackage

/* verilog/op_class_check.sv */
// Decides whether an operation class may follow the indexed-execute prefix.
// Assumes the class code comes straight from the instruction decoder.
`timescale 1ns/1ps
module op_class_check (
	input wire idx_sub_pkg::op_e op_in,
	output logic permitted_out
);
	// A second prefix or the OP_OTHER class is refused; unlisted codes 4'hB to 4'hE are permitted.
	assign permitted_out = (op_in != idx_sub_pkg::OP_DO) && (op_in != idx_sub_pkg::OP_OTHER);
endmodule

/* dv/idx_sub_monitor.sv */
// Concurrent checks on the ports of the indexed operand substitution block.
// Assumes the single clock clk_in and the instruction and index handshakes of the block.
`timescale 1ns/1ps
module idx_sub_monitor (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic instr_valid_in,
	input wire idx_sub_pkg::instr_s instr_in,
	input wire logic instr_ready_out,
	input wire logic logic_result_bit_in,
	input wire logic idx_req_out,
	input wire idx_sub_pkg::index_req_s idx_sel_out,
	input wire logic idx_valid_in,
	input wire logic [idx_sub_pkg::WORD_W-1:0] idx_data_in,
	input wire logic exec_valid_out,
	input wire idx_sub_pkg::exec_s exec_out,
	input wire logic illegal_pair_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	// Index word taken, then the following word offered at once.
	sequence s_got;
		!instr_ready_out && idx_valid_in ##1 instr_valid_in;
	endsequence
	chk_fetch_wait: assert property (idx_req_out |-> !instr_ready_out) else $error("ready during fetch");
	chk_ready_back: assert property (!instr_ready_out && idx_valid_in |=> instr_ready_out)
		else $error("ready not back");
	chk_word_sel: assert property (idx_req_out |-> idx_sel_out.word_num == $past(instr_in.param[7:0]))
		else $error("wrong word number");
	chk_sub_value: assert property (s_got ##0 !(instr_in.op inside {idx_sub_pkg::OP_DO, idx_sub_pkg::OP_OTHER})
		|=> exec_valid_out && exec_out.indexed && exec_out.param == $past(idx_data_in, 2)) else $error("bad subst");
	chk_byte_split: assert property (exec_valid_out && exec_out.indexed |-> exec_out.byte_addr == exec_out.param[7:0]
		&& exec_out.bit_num == ((exec_out.opnd inside {idx_sub_pkg::OPND_INPUT, idx_sub_pkg::OPND_OUTPUT,
		idx_sub_pkg::OPND_FLAG}) ? exec_out.param[15:8] : 8'h00)) else $error("bad split");
	chk_input_remap: assert property (s_got ##0 instr_in.op == idx_sub_pkg::OP_AND
		&& instr_in.opnd == idx_sub_pkg::OPND_INPUT && idx_sel_out.space == idx_sub_pkg::SPACE_FLAG_WORD
		&& $past(idx_data_in[7]) |=> exec_out.opnd == idx_sub_pkg::OPND_OUTPUT) else $error("no remap");
	chk_bad_pair: assert property (s_got ##0 instr_in.op == idx_sub_pkg::OP_OTHER
		|=> illegal_pair_out && !exec_valid_out) else $error("bad pair ran");
	chk_one_shot: assert property (exec_valid_out && exec_out.indexed |=> !(exec_valid_out && exec_out.indexed))
		else $error("second subst");
	chk_plain_param: assert property (exec_valid_out && !exec_out.indexed |-> exec_out.param == $past(instr_in.param))
		else $error("plain param");
endmodule
bind indexed_operand_substitution idx_sub_monitor u_mon (.*);

/* dv/indexed_operand_substitution_tb_top.sv */
// Self-checking bench for indexed operand substitution.
// Assumes the checker file is compiled with it; the bench answers index fetches itself.
`timescale 1ns/1ps
module indexed_operand_substitution_tb_top;
	typedef struct {idx_sub_pkg::op_e op; idx_sub_pkg::space_e sp; logic [15:0] d; idx_sub_pkg::opnd_e o;} row_s;
	logic clk_in = 0, rstn_in = 0, vld = 0, lrb = 0, ivld = 0, rdy, req, ev, ill;
	logic [15:0] idat = 16'h0000;
	idx_sub_pkg::instr_s ins = '0;
	idx_sub_pkg::index_req_s sel;
	idx_sub_pkg::exec_s ex;
	int err_count = 0, checks = 0;
	row_s rows [3] = '{'{idx_sub_pkg::OP_AND, idx_sub_pkg::SPACE_FLAG_WORD, 16'h0080, idx_sub_pkg::OPND_OUTPUT},
		'{idx_sub_pkg::OP_AND, idx_sub_pkg::SPACE_FLAG_WORD, 16'h037F, idx_sub_pkg::OPND_INPUT},
		'{idx_sub_pkg::OP_AND, idx_sub_pkg::SPACE_DATA_WORD, 16'h0188, idx_sub_pkg::OPND_INPUT}};
	indexed_operand_substitution u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .instr_valid_in(vld), .instr_in(ins),
		.instr_ready_out(rdy), .logic_result_bit_in(lrb), .idx_req_out(req), .idx_sel_out(sel), .idx_valid_in(ivld),
		.idx_data_in(idat), .exec_valid_out(ev), .exec_out(ex), .illegal_pair_out(ill));
	initial forever #4 clk_in = ~clk_in;
	always @(posedge clk_in) lrb <= ~lrb;
	task chk(input string n, input logic [31:0] s, e);
		checks++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task send(input idx_sub_pkg::instr_s w);
		vld <= 1'b1;
		ins <= w;
		@(posedge clk_in);
		vld <= 1'b0;
		#1;
	endtask
	// Index data is inverted once released so a stale value cannot pass.
	task do_seq(input row_s r);
		logic bad;
		bad = r.op inside {idx_sub_pkg::OP_DO, idx_sub_pkg::OP_OTHER};
		@(posedge clk_in);
		send('{idx_sub_pkg::OP_DO, idx_sub_pkg::OPND_NONE, r.sp, 16'h00FF});
		chk("sel", sel, {r.sp, 8'hFF});
		chk("req", {req, rdy}, 2'h2);
		@(posedge clk_in);
		ivld <= 1'b1;
		idat <= r.d;
		@(posedge clk_in);
		ivld <= 1'b0;
		idat <= ~r.d;
		send('{r.op, idx_sub_pkg::OPND_INPUT, idx_sub_pkg::SPACE_FLAG_WORD, 16'h0000});
		chk("ill", ill, bad);
		chk("ev", ev, !bad);
		if (!bad) begin
			chk("param", ex.param, r.d);
			chk("byte", ex.byte_addr, r.d[7:0]);
			chk("bit", ex.bit_num, r.d[15:8]);
			chk("opnd", ex.opnd, r.o);
		end
	endtask
	task stop_test;
		$display("mismatches %0d checks %0d", err_count, checks);
		if (err_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#100us;
		err_count++;
		stop_test;
	end
	initial begin
		repeat (12) @(posedge clk_in);
		#1;
		chk("reset", {rdy, req, ev, ill}, 4'h8);
		@(posedge clk_in);
		rstn_in <= 1'b1;
		foreach (rows[i]) do_seq(rows[i]);
		for (int i = 1; i < 10; i++) do_seq('{idx_sub_pkg::op_e'(i), idx_sub_pkg::SPACE_FLAG_WORD, 16'h0085,
			idx_sub_pkg::OPND_INPUT});
		@(posedge clk_in);
		send('{idx_sub_pkg::OP_TIMER, idx_sub_pkg::OPND_OTHER, idx_sub_pkg::SPACE_FLAG_WORD, 16'h0003});
		chk("plain", {ex.indexed, ex.param}, 17'h00003);
		do_seq('{idx_sub_pkg::OP_OTHER, idx_sub_pkg::SPACE_DATA_WORD, 16'h0001, idx_sub_pkg::OPND_INPUT});
		do_seq('{idx_sub_pkg::OP_DO, idx_sub_pkg::SPACE_FLAG_WORD, 16'h0002, idx_sub_pkg::OPND_INPUT});
		stop_test;
	end
endmodule
